/* core_model.sv */
// Behavioural core and memory on the far side of the sequencer.
// Assumes mem_cmd is registered on posedge clk by the sequencer.
`timescale 1ns/1ps
module core_model import intc_pkg::*; #(
   parameter logic [15:0] PC_VAL = 16'h1235,
   parameter logic [15:0] STACK_VAL = 16'h0f00,
   parameter logic [7:0] CODES_VAL = 8'h5a
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bench controls
   input wire logic unmask,
   input wire logic boundary_en,
   // Sequencer side
   input wire logic mask_set,
   input wire logic entry_busy,
   input wire mem_cmd_s mem_cmd,
   output core_view_s core,
   output logic [15:0] mem_rdata
);
   logic mask_r;
   logic [1:0] gap_r;
   logic [15:0] junk_r;

   // Mask set by entry, cleared only when the bench asks
   always_ff @(posedge clk) begin
      if (!resetn || mask_set) begin
         mask_r <= 1'b1;
      end else if (unmask) begin
         mask_r <= 1'b0;
      end
   end

   // Instruction length counter, and a bus pattern that never holds
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gap_r <= 2'h0;
         junk_r <= 16'h0f0f;
      end else begin
         gap_r <= gap_r + 2'h1;
         junk_r <= ~junk_r;
      end
   end

   // Boundaries stop during entry, as the core is busy stacking
   always_comb begin
      core.boundary = boundary_en && !entry_busy && gap_r == 2'h3;
      core.mask_bit = mask_r;
      core.cond_codes = CODES_VAL;
      core.pc = PC_VAL;
      core.stack_pointer = STACK_VAL;
      if (mem_cmd.req && !mem_cmd.we) begin
         mem_rdata = {4'h8, mem_cmd.addr[11:0]} | 16'h0001;
      end else begin
         mem_rdata = junk_r;
      end
   end
endmodule

/* intc_pkg.sv */
// Shared constants and types of the interrupt accept sequencer.
// Assumes one 40 MHz clock; one entry state is one clock cycle.
package intc_pkg;
   // Source layout: four edge pins, the event input, three peripherals
   localparam int NSRC = 8;
   localparam int NEXT = 4;
   localparam int NEDGE = 5;
   localparam int SRC_EVT = 4;
   localparam int NPERIPH = 3;

   // Entry phase lengths in states (cycles)
   localparam logic [3:0] SAVE_STATES = 4'h3 + 4'h1;
   localparam logic [3:0] VEC_STATES = 4'h2;
   localparam logic [3:0] IFETCH_STATES = 4'h4;
   localparam logic [3:0] INTERN_STATES = 4'h4;
   // Instruction wait range, not counting the block move instruction
   localparam int WAIT_MIN = 1;
   localparam int WAIT_MAX = 13;
   // Cycles from acceptance to handler start pulse
   localparam int ENTRY_CYCLES = 15;

   // Stack and address handling
   localparam logic [15:0] STACK_WORD = 16'h0002;
   localparam logic [15:0] WORD_ALIGN = 16'hFFFE;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // Synchroniser idle: edge pins high (held inverted), event input high
   localparam logic [NEDGE-1:0] SYNC_RESET = 5'h10;

   // Edge modes: two select bits
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;

   // Vector numbers per source, index 0 is highest priority
   localparam logic [7:0] VEC_NUM [NSRC] = '{
      8'h04, 8'h05, 8'h07, 8'h08, 8'h06, 8'h0B, 8'h0C, 8'h0D};

   // Memory command toward the core's bus unit
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_s;

   // Core state seen at an instruction boundary
   typedef struct packed {
      logic boundary;
      logic mask_bit;
      logic [7:0] cond_codes;
      logic [15:0] pc;
      logic [15:0] stack_pointer;
   } core_view_s;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_SAVE = 5'b0_0010,
      ST_VEC = 5'b0_0100,
      ST_IFETCH = 5'b0_1000,
      ST_INTERN = 5'b1_0000
   } entry_state_e;
endpackage

/* interrupt_accept_sequencer.sv */
// Interrupt controller: request flags, priority pick, exception entry.
// Assumes the core pulses boundary when an instruction completes and
// answers stack writes and the vector read in fixed single states.
//
// Contract
// [RULE1] Enabled conditions alone forward a request
// [RULE2] A received request sets its flag
// [RULE3] Highest priority flag chosen, others stay pending
// [RULE4] Accept only while mask bit is zero
// [RULE5] Push next PC and condition codes
// [RULE6] Entry sets the global mask bit
// [RULE7] Fetch vector of accepted source, jump there
// [RULE8] Request colliding with clear still taken after
// [RULE9] Software clears bits only while masked
// [RULE10] Wait instruction end, fifteen to 27 total
// [RULE11] Save four, vector two, fetch four, internal four
// [RULE12] Word accesses force address bit zero low
// [RULE13] Condition codes saved as word, even byte restored
// [RULE14] Software keeps stack pointer even
// [RULE15] Pin function switch may set a flag
// [RULE16] Function 0 to 1, pin low, falling set
// [RULE17] Function 1 to 0, pin low, rising set
// [RULE18] Event source switch forming selected edge sets
// [RULE19] Software clears flag after function switch
// [RULE20] Flags clear only by writing zero
// [RULE21] Edge pin 0 highest, pin 4 lowest
// [RULE22] Pending flags re-judged each instruction boundary
`timescale 1ns/1ps
module interrupt_accept_sequencer import intc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // External request pins, active low, asynchronous
   input wire logic [NEXT-1:0] ext_req_pin_n,
   input wire logic event_input_pin,
   // Same-domain event sources
   input wire logic internal_pwm_event,
   input wire logic [NPERIPH-1:0] periph_cond,
   // Pin function and edge configuration
   input wire logic [NEXT-1:0] port_func,
   input wire logic [NEXT-1:0] edge_sel,
   input wire logic event_source_select,
   input wire logic event_edge_sel_hi,
   input wire logic event_edge_sel_lo,
   input wire logic [NSRC-1:0] int_enable,
   // Flag register access, bits written 0 clear
   input wire logic flag_wr,
   input wire logic [NSRC-1:0] flag_wr_data,
   output logic [NSRC-1:0] request_flags,
   // Core view and memory port
   input wire core_view_s core,
   input wire logic [15:0] mem_rdata,
   output mem_cmd_s mem_cmd,
   // Entry results
   output logic entry_busy,
   output logic mask_set,
   output logic [2:0] accepted_src,
   output logic [15:0] stack_pointer_out,
   output logic handler_go,
   output logic [15:0] handler_pc,
   // Return from exception condition-code restore
   input wire logic ret_load,
   input wire logic [15:0] ret_word,
   output logic ret_codes_valid,
   output logic [7:0] ret_codes
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [NEDGE-1:0] sync1_r, sync2_r, sync3_r, filt_r;
   logic [NEDGE-1:0] src_level;
   logic [NEDGE-1:0][1:0] src_mode;
   logic [NEDGE-1:0] edge_hit;
   logic [NSRC-1:0] cond, req, flag_r, flag_clr;
   logic [2:0] pick_idx, sel_r;
   logic pending, accept;
   entry_state_e st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [15:0] stack_even, vec_addr;
   mem_cmd_s mem_r;
   logic mask_set_r, go_r, ret_v_r;
   logic [15:0] go_pc_r, stack_base_r;
   logic [7:0] ret_codes_r;

   // Three-stage pin synchroniser; stage one feeds stage two only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_r <= SYNC_RESET;
         sync2_r <= SYNC_RESET;
         sync3_r <= SYNC_RESET;
      end else begin
         sync1_r <= {event_input_pin, ~ext_req_pin_n};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Accept a level change once stages two and three agree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         filt_r <= SYNC_RESET; // Idle levels, so no false edge after reset
      end else begin
         filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
      end
   end

   // Deselected pins read high, so a switch can itself form an edge
   genvar g;
   generate
      for (g = 0; g < NEXT; g++) begin : g_ext
         // filt holds the inverted active-low pin; restore pin level
         assign src_level[g] = port_func[g] ? ~filt_r[g] : 1'b1; // RULE15
         assign src_mode[g] = {1'b0, edge_sel[g]}; // RULE16 RULE17
      end
   endgenerate

   // Event input picks pin or internal PWM; a switch may form an edge
   assign src_level[SRC_EVT] = event_source_select ? internal_pwm_event :
                               filt_r[SRC_EVT]; // RULE18
   assign src_mode[SRC_EVT] = {event_edge_sel_hi, event_edge_sel_lo};

   src_edge_detect #(
      .N(NEDGE)
   ) u_edges (
      .clk(clk),
      .resetn(resetn),
      .level(src_level),
      .mode(src_mode),
      .hit(edge_hit)
   );

   // Only enabled conditions reach the flags
   assign cond = {periph_cond, edge_hit};
   assign req = cond & int_enable; // RULE1
   assign flag_clr = flag_wr ? ~flag_wr_data : '0;

   // Set beats a same-cycle clear; acceptance never clears a flag
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flag_r <= FLAGS_RESET;
      end else begin
         flag_r <= (flag_r & ~flag_clr) | req; // RULE2 RULE8 RULE20
      end
   end
   assign request_flags = flag_r;

   // Lowest index wins: edge pin 0 first, pin 4 after pins 1 to 3
   always_comb begin
      pick_idx = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (flag_r[i]) begin
            pick_idx = 3'(i); // RULE3 RULE21
         end
      end
   end
   assign pending = |flag_r;

   // Judged afresh at each boundary while idle and unmasked
   assign accept = (st_r == ST_IDLE) && core.boundary && pending &&
                   !core.mask_bit; // RULE4 RULE22

   // Entry phase sequencing
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 4'h1;
      case (st_r)
         ST_IDLE: begin
            cnt_nxt = 4'h0;
            if (accept) begin
               st_nxt = ST_SAVE; // RULE10
            end
         end
         ST_SAVE: begin
            if (cnt_r == SAVE_STATES - 4'h1) begin
               st_nxt = ST_VEC; // RULE11
               cnt_nxt = 4'h0;
            end
         end
         ST_VEC: begin
            if (cnt_r == VEC_STATES - 4'h1) begin
               st_nxt = ST_IFETCH; // RULE11
               cnt_nxt = 4'h0;
            end
         end
         ST_IFETCH: begin
            if (cnt_r == IFETCH_STATES - 4'h1) begin
               st_nxt = ST_INTERN;
               cnt_nxt = 4'h0;
            end
         end
         ST_INTERN: begin
            if (cnt_r == INTERN_STATES - 4'h1) begin
               st_nxt = ST_IDLE;
               cnt_nxt = 4'h0;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            cnt_nxt = 4'h0;
         end
      endcase
   end

   // State and phase counter
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= ST_IDLE;
         cnt_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Latch source and stack base at acceptance
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_r <= 3'h0;
         stack_base_r <= 16'h0000;
      end else if (accept) begin
         sel_r <= pick_idx;
         stack_base_r <= (core.stack_pointer & WORD_ALIGN) -
                         (STACK_WORD + STACK_WORD);
      end
   end
   assign stack_even = stack_base_r & WORD_ALIGN;
   assign vec_addr = {7'h00, VEC_NUM[sel_r], 1'b0} & WORD_ALIGN; // RULE7

   // Bus commands: PC word above, code word below, then vector read
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mem_r <= '0;
      end else if (accept) begin
         mem_r.req <= 1'b1;
         mem_r.we <= 1'b1;
         mem_r.addr <= ((core.stack_pointer & WORD_ALIGN) - STACK_WORD) &
                       WORD_ALIGN; // RULE5 RULE12
         mem_r.wdata <= core.pc & WORD_ALIGN;
      end else if (st_r == ST_SAVE && cnt_r == 4'h1) begin
         mem_r.addr <= stack_even; // RULE12
         mem_r.wdata <= {core.cond_codes, core.cond_codes}; // RULE13
      end else if (st_r == ST_SAVE && cnt_r == SAVE_STATES - 4'h1) begin
         mem_r.we <= 1'b0;
         mem_r.addr <= vec_addr;
         mem_r.wdata <= 16'h0000;
      end else if (st_r == ST_VEC && cnt_r == VEC_STATES - 4'h1) begin
         mem_r <= '0;
      end
   end
   assign mem_cmd = mem_r;

   // Mask raised as entry starts; handler address taken at vector read end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mask_set_r <= 1'b0;
         go_pc_r <= 16'h0000;
         go_r <= 1'b0;
      end else begin
         mask_set_r <= accept; // RULE6
         go_r <= (st_r == ST_INTERN) && (cnt_r == INTERN_STATES - 4'h1);
         if (st_r == ST_VEC && cnt_r == VEC_STATES - 4'h1) begin
            go_pc_r <= mem_rdata & WORD_ALIGN; // RULE7
         end
      end
   end

   // Condition codes come back from the even, upper byte only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ret_codes_r <= 8'h00;
         ret_v_r <= 1'b0;
      end else begin
         ret_v_r <= ret_load;
         if (ret_load) begin
            ret_codes_r <= ret_word[15:8]; // RULE13
         end
      end
   end

   // Output drive
   assign entry_busy = (st_r != ST_IDLE);
   assign mask_set = mask_set_r;
   assign accepted_src = sel_r;
   assign stack_pointer_out = stack_base_r;
   assign handler_go = go_r;
   assign handler_pc = go_pc_r;
   assign ret_codes_valid = ret_v_r;
   assign ret_codes = ret_codes_r;

   // Checks on the entry sequence
   sequence save_s;
      (mem_cmd.req && mem_cmd.we)[*4];
   endsequence
   sequence vec_s;
      (mem_cmd.req && !mem_cmd.we && mem_cmd.addr == vec_addr)[*2];
   endsequence

   flag_set_a: assert property ((|req) |=> // RULE2
      ((flag_r & $past(req)) == $past(req)))
      else $error("request did not set flag");
   no_autoclr_a: assert property (!flag_wr |=> // RULE20
      ((flag_r & $past(flag_r)) == $past(flag_r)))
      else $error("flag cleared itself");
   mask_hold_a: assert property (core.mask_bit && !entry_busy |=> // RULE4
      !entry_busy) else $error("entry started while masked");
   best_pick_a: assert property (accept |-> flag_r[pick_idx] && // RULE3
      ((flag_r & ((8'h01 << pick_idx) - 8'h01)) == 8'h00))
      else $error("not highest priority");
   entry_seq_a: assert property (accept |=> save_s ##1 vec_s) // RULE11
      else $error("entry phases wrong");
   mask_set_a: assert property (accept |=> mask_set && entry_busy) // RULE6
      else $error("mask not raised");
   handler_time_a: assert property (accept |-> ##15 handler_go) // RULE10
      else $error("handler start late");
   even_addr_a: assert property (mem_cmd.req |-> !mem_cmd.addr[0]) // RULE12
      else $error("odd word address");
   codes_word_a: assert property (accept |=> ##2 // RULE13
      (mem_cmd.wdata[15:8] == mem_cmd.wdata[7:0]))
      else $error("code byte mismatch");
   func_on_a: assert property ($rose(port_func[0]) && filt_r[0] && // RULE16
      !edge_sel[0] && int_enable[0] |=> flag_r[0])
      else $error("switch-on edge missed");
   func_off_a: assert property ($fell(port_func[0]) && filt_r[0] && // RULE17
      edge_sel[0] && int_enable[0] |=> flag_r[0])
      else $error("switch-off edge missed");
endmodule

/* src_edge_detect.sv */
// Per-channel edge detector for request sources.
// Assumes levels are already in the clk domain; mode per channel.
`timescale 1ns/1ps
module src_edge_detect import intc_pkg::*; #(
   parameter int N = NEDGE
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Source levels and edge modes
   input wire logic [N-1:0] level,
   input wire logic [N-1:0][1:0] mode,
   // One-cycle edge pulses
   output logic [N-1:0] hit
);
   logic [N-1:0] prev_r;

   // Idle level is high, so reset must not fake a falling edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_r <= '1;
      end else begin
         prev_r <= level;
      end
   end

   // Edge match per channel
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic rise;
         logic fall;
         assign rise = level[g] & ~prev_r[g];
         assign fall = ~level[g] & prev_r[g];
         assign hit[g] = mode[g][1] ? (rise | fall) :
                         (mode[g] == EDGE_RISE) ? rise : fall;
      end
   endgenerate
endmodule

/* tb_top.sv */
// Self-checking bench of the interrupt accept sequencer.
// Assumes core_model stands for the core and the vector memory.
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
   begin \
      check_count++; \
      if ((ac) !== (ex)) begin \
         err_count++; \
         $display("FAIL %s expected %h seen %h", nm, ex, ac); \
      end \
   end
module tb_top import intc_pkg::*;;
   localparam logic [15:0] STACK_INIT = 16'h0f00;
   localparam logic [15:0] PC = 16'h1235;
   localparam logic [7:0] CODES = 8'h5a;
   logic clk = 0;
   logic resetn = 0;
   logic [NEXT-1:0] ext_req_pin_n = 4'hf;
   logic event_input_pin = 0;
   logic internal_pwm_event = 1;
   logic [NPERIPH-1:0] periph_cond = 0;
   logic [NEXT-1:0] port_func = 0;
   logic [NEXT-1:0] edge_sel = 0;
   logic event_source_select = 1;
   logic event_edge_sel_hi = 0;
   logic event_edge_sel_lo = 0;
   logic [NSRC-1:0] int_enable = 8'h1f;
   logic flag_wr = 0;
   logic [NSRC-1:0] flag_wr_data = 8'hff;
   logic [NSRC-1:0] request_flags;
   core_view_s core;
   logic [15:0] mem_rdata;
   mem_cmd_s mem_cmd;
   logic entry_busy, mask_set, handler_go, ret_codes_valid;
   logic [2:0] accepted_src;
   logic [15:0] stack_pointer_out, handler_pc;
   logic ret_load = 0;
   logic [15:0] ret_word = 16'h0000;
   logic [7:0] ret_codes;
   logic unmask = 0;
   int err_count = 0;
   int check_count = 0;
   int ms_count = 0;

   interrupt_accept_sequencer interrupt_accept_sequencer_i (.clk(clk),
      .resetn(resetn), .ext_req_pin_n(ext_req_pin_n),
      .event_input_pin(event_input_pin),
      .internal_pwm_event(internal_pwm_event), .periph_cond(periph_cond),
      .port_func(port_func), .edge_sel(edge_sel),
      .event_source_select(event_source_select),
      .event_edge_sel_hi(event_edge_sel_hi),
      .event_edge_sel_lo(event_edge_sel_lo), .int_enable(int_enable),
      .flag_wr(flag_wr), .flag_wr_data(flag_wr_data),
      .request_flags(request_flags), .core(core), .mem_rdata(mem_rdata),
      .mem_cmd(mem_cmd), .entry_busy(entry_busy), .mask_set(mask_set),
      .accepted_src(accepted_src), .stack_pointer_out(stack_pointer_out),
      .handler_go(handler_go), .handler_pc(handler_pc),
      .ret_load(ret_load), .ret_word(ret_word),
      .ret_codes_valid(ret_codes_valid), .ret_codes(ret_codes));
   core_model #(.PC_VAL(PC), .STACK_VAL(STACK_INIT), .CODES_VAL(CODES))
      core_model_i (
      .clk(clk), .resetn(resetn), .unmask(unmask), .boundary_en(resetn),
      .mask_set(mask_set), .entry_busy(entry_busy), .mem_cmd(mem_cmd),
      .core(core), .mem_rdata(mem_rdata));

   // Clock, 25 ns period
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Entry count, to show that masked requests wait
   always @(posedge clk) begin
      if (mask_set === 1'b1) ms_count++;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One flag write pulse, then time to land
   task automatic pulse_wr(input logic [7:0] d);
      tick(1);
      flag_wr <= 1'b1;
      flag_wr_data <= d;
      tick(1);
      flag_wr <= 1'b0;
      tick(2);
      #1;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Enable gating, write semantics, masked requests stay pending
   task automatic t_flags();
      tick(1);
      periph_cond <= 3'h1;
      tick(1);
      periph_cond <= 3'h0;
      tick(3);
      #1;
      `CHK("flag5 disabled", 1'b0, request_flags[5])
      int_enable <= 8'hff;
      periph_cond <= 3'h1;
      tick(1);
      periph_cond <= 3'h0;
      tick(3);
      #1;
      `CHK("flag5 set", 1'b1, request_flags[5])
      pulse_wr(8'hff);
      `CHK("flag5 after ones", 1'b1, request_flags[5])
      pulse_wr(8'hdf);
      `CHK("flag5 cleared", 1'b0, request_flags[5])
      // Clear and a new request in one cycle: the request survives
      periph_cond <= 3'h5;
      flag_wr <= 1'b1;
      flag_wr_data <= 8'h5f;
      tick(1);
      periph_cond <= 3'h0;
      flag_wr <= 1'b0;
      tick(12);
      #1;
      `CHK("flags kept", 2'b11, {request_flags[7], request_flags[5]})
      `CHK("no entry masked", 0, ms_count)
   endtask

   // Unmask, follow one entry and judge the save, vector read and handler start
   task automatic t_entry(input logic [2:0] src, input logic [7:0] vnum);
      logic [15:0] va;
      logic [15:0] base;
      int n;
      va = {7'h00, vnum, 1'b0};
      base = STACK_INIT & 16'hfffe;
      n = 0;
      tick(1);
      unmask <= 1'b1;
      tick(1);
      unmask <= 1'b0;
      do begin
         tick(1);
         #1;
         n++;
      end while (mask_set !== 1'b1 && n < 40);
      `CHK("source", src, accepted_src)
      `CHK("pc cmd", 2'b11, {mem_cmd.req, mem_cmd.we})
      `CHK("pc addr", base - 16'h0002, mem_cmd.addr)
      `CHK("pc word", PC & 16'hfffe, mem_cmd.wdata)
      `CHK("stack out", base - 16'h0004, stack_pointer_out)
      `CHK("busy on", 1'b1, entry_busy)
      tick(2);
      #1;
      `CHK("code addr", base - 16'h0004, mem_cmd.addr)
      `CHK("code word", {CODES, CODES}, mem_cmd.wdata)
      `CHK("mask pulse", 1'b0, mask_set)
      tick(2);
      #1;
      `CHK("vec cmd", 2'b10, {mem_cmd.req, mem_cmd.we})
      `CHK("vec addr", va, mem_cmd.addr)
      tick(10);
      #1;
      `CHK("go time", 1'b1, handler_go)
      `CHK("busy off", 1'b0, entry_busy)
      `CHK("handler", {4'h8, va[11:0]} & 16'hfffe, handler_pc)
      `CHK("flag kept", 1'b1, request_flags[src])
   endtask

   // Pin function switches with the pins held low
   task automatic t_pins();
      ext_req_pin_n <= 4'ha;
      tick(8);
      port_func <= 4'h5;
      tick(8);
      #1;
      `CHK("switch on", 4'h5, request_flags[3:0])
      t_entry(3'h0, 8'h04);
      pulse_wr(8'hf0);
      edge_sel <= 4'h5;
      tick(8);
      port_func <= 4'h0;
      tick(8);
      #1;
      `CHK("switch off", 4'h5, request_flags[3:0])
      pulse_wr(8'hf0);
      ext_req_pin_n <= 4'hf;
   endtask

   // Event source switch, falling mode: pwm high to pin low sets
   task automatic t_event();
      event_source_select <= 1'b0;
      tick(8);
      #1;
      `CHK("event falls", 1'b1, request_flags[SRC_EVT])
      pulse_wr(8'hef);
      event_source_select <= 1'b1;
      tick(8);
      #1;
      `CHK("event rises", 1'b0, request_flags[SRC_EVT])
      // Rising mode: pwm high to pin low stays quiet, back again sets
      event_edge_sel_lo <= 1'b1;
      event_source_select <= 1'b0;
      tick(8);
      #1;
      `CHK("rise mode off", 1'b0, request_flags[SRC_EVT])
      event_source_select <= 1'b1;
      tick(8);
      #1;
      `CHK("rise mode on", 1'b1, request_flags[SRC_EVT])
      pulse_wr(8'hef);
   endtask

   // Restore pulse stands for the one cycle after the load
   task automatic t_rte();
      ret_load <= 1'b1;
      ret_word <= 16'ha55a;
      tick(1);
      ret_load <= 1'b0;
      #1;
      `CHK("restore valid", 1'b1, ret_codes_valid)
      `CHK("restore codes", 8'ha5, ret_codes)
      tick(1);
      #1;
      `CHK("restore pulse", 1'b0, ret_codes_valid)
   endtask

   // Main sequence
   initial begin
      tick(5);
      resetn <= 1'b1;
      tick(4);
      t_flags();
      t_entry(3'h5, 8'h0b);
      pulse_wr(8'hdf);
      t_entry(3'h7, 8'h0d);
      pulse_wr(8'h7f);
      t_pins();
      t_event();
      t_rte();
      give_verdict();
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #(25 * 5000);
      err_count++;
      give_verdict();
   end
endmodule
